/* ufc_top.sv */
// Purpose: fifo control and dma ready signalling for one uart channel, with axi4-lite registers
// Assumes: one clock, synchronous active-high reset, receiver time-out pulse supplied from outside
// Notes: instantiate once per channel; each instance holds its own control state
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "ufc_regs.svh"

module ufc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } ufc_fifo_state_t;

    ufc_fifo_state_t st_r;
    ufc_fifo_state_t st_nxt;
    logic push;
    logic pop;

    assign in_ready_o = (st_r.count != CW'(DEPTH));
    assign out_valid_o = (st_r.count != '0);
    assign out_data_o = st_r.mem[st_r.rd_ptr];
    assign count_o = st_r.count;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // depth must be a power of two so the pointers wrap by themselves
    always_comb begin
        st_nxt = st_r;
        if (clear_i) begin
            st_nxt.wr_ptr = '0;
            st_nxt.rd_ptr = '0;
            st_nxt.count = '0;
        end else begin
            if (push) begin
                st_nxt.mem[st_r.wr_ptr] = in_data_i;
                st_nxt.wr_ptr = st_r.wr_ptr + PW'(1);
            end
            if (pop) begin
                st_nxt.rd_ptr = st_r.rd_ptr + PW'(1);
            end
            st_nxt.count = st_r.count + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : ufc_fifo

////////////////////////////////////////////////////////////////////////////////////////////////////

module ufc_top (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [`UFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`UFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [`UFC_DATA_W-1:0] tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic [`UFC_DATA_W-1:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic rx_timeout_i,
    output ufc_pkg::ufc_cfg_t cfg_o,
    output logic tx_dma_request_n_o,
    output logic rx_dma_request_n_o
);
    import ufc_pkg::*;

    ufc_state_t st_r;
    ufc_state_t st_nxt;
    logic [`UFC_CNT_W-1:0] tx_cnt;
    logic [`UFC_CNT_W-1:0] rx_cnt;
    logic [`UFC_CNT_W-1:0] limit;
    logic [`UFC_CNT_W-1:0] rx_thr;
    logic [`UFC_CNT_W-1:0] tx_thr;
    logic [`UFC_DATA_W-1:0] rx_head;
    logic rx_head_valid;
    logic mode1;
    logic wr_exec;
    logic rd_exec;
    logic tx_push;
    logic rx_pop;
    logic rx_in_ready;
    logic rx_thr_reached;
    logic tx_below_thr;

    function automatic logic [`UFC_CNT_W-1:0] rx_level(input logic [1:0] f);
        case (f)
            2'h0: rx_level = `UFC_RX_THR_0;
            2'h1: rx_level = `UFC_RX_THR_1;
            2'h2: rx_level = `UFC_RX_THR_2;
            default: rx_level = `UFC_RX_THR_3;
        endcase
    endfunction : rx_level

    function automatic logic [`UFC_CNT_W-1:0] tx_level(input logic [1:0] f);
        case (f)
            2'h0: tx_level = `UFC_TX_THR_0;
            2'h1: tx_level = `UFC_TX_THR_1;
            2'h2: tx_level = `UFC_TX_THR_2;
            default: tx_level = `UFC_TX_THR_3;
        endcase
    endfunction : tx_level

    function automatic logic is_reg(input logic [`UFC_ADDR_W-1:0] a, input logic [`UFC_ADDR_W-1:0] off);
        is_reg = (a == off);
    endfunction : is_reg

    ////////////////////////////////////////////////////////////////////////////////////////////////

    assign rx_thr = rx_level(st_r.cfg.rx_thr_field);
    assign tx_thr = tx_level(st_r.cfg.tx_thr_field);
    assign mode1 = st_r.cfg.enable && st_r.cfg.dma_mode;
    // fifos off: limit of one, so a byte is taken only into an empty side
    assign limit = st_r.cfg.enable ? `UFC_FIFO_FULL : `UFC_LIMIT_DISABLED;
    // reached flag; rx keeps filling to the limit
    assign rx_thr_reached = (rx_cnt >= rx_thr);
    assign tx_below_thr = (tx_cnt < tx_thr);

    assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign cfg_o = st_r.cfg;
    assign tx_dma_request_n_o = st_r.tx_req_n;
    assign rx_dma_request_n_o = st_r.rx_req_n;

    assign wr_exec = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    assign rd_exec = s_axi_arvalid && s_axi_arready;
    // overrun: a write to a full transmit side is answered but the byte is dropped
    assign tx_push = wr_exec && is_reg(st_r.aw_addr, `UFC_OFF_TX_HOLDING) && st_r.w_strb[0] && (tx_cnt < limit);
    assign rx_pop = rd_exec && is_reg(s_axi_araddr, `UFC_OFF_RX_HOLDING) && rx_head_valid;
    assign rx_ready_o = rx_in_ready && (rx_cnt < limit);

    ufc_fifo #(.WIDTH(`UFC_DATA_W), .DEPTH(`UFC_FIFO_DEPTH)) u_tx_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(st_r.tx_clr),
        .in_valid_i(tx_push),
        .in_ready_o(),
        .in_data_i(st_r.w_data[`UFC_DATA_W-1:0]),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o),
        .count_o(tx_cnt)
    );

    ufc_fifo #(.WIDTH(`UFC_DATA_W), .DEPTH(`UFC_FIFO_DEPTH)) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .clear_i(st_r.rx_clr),
        .in_valid_i(rx_valid_i && (rx_cnt < limit)),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_data_i),
        .out_valid_o(rx_head_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_head),
        .count_o(rx_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_clr = 1'b0;
        st_nxt.rx_clr = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (wr_exec) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = `UFC_RESP_OKAY;
            if (is_reg(st_r.aw_addr, `UFC_OFF_FIFO_CONTROL)) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.cfg.enable = st_r.w_data[`UFC_FCR_EN_BIT];
                    // other fields only with enable set
                    if (st_r.w_data[`UFC_FCR_EN_BIT]) begin
                        st_nxt.cfg.dma_mode = st_r.w_data[`UFC_FCR_DMA_BIT];
                        st_nxt.cfg.tx_thr_field = st_r.w_data[`UFC_FCR_TXTHR_LSB +: 2];
                        st_nxt.cfg.rx_thr_field = st_r.w_data[`UFC_FCR_RXTHR_LSB +: 2];
                        st_nxt.tx_clr = st_r.w_data[`UFC_FCR_TXCLR_BIT];
                        st_nxt.rx_clr = st_r.w_data[`UFC_FCR_RXCLR_BIT];
                    end
                end
            end else if (!is_reg(st_r.aw_addr, `UFC_OFF_TX_HOLDING)) begin
                st_nxt.bresp = `UFC_RESP_SLVERR;
            end
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (rd_exec) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = `UFC_RESP_OKAY;
            st_nxt.rdata = 32'h0;
            case (s_axi_araddr)
                `UFC_OFF_FIFO_CONTROL: st_nxt.rdata = 32'h0;
                `UFC_OFF_TX_HOLDING: st_nxt.rdata = 32'h0;
                `UFC_OFF_RX_HOLDING: st_nxt.rdata = {24'h0, rx_head_valid ? rx_head : 8'h00};
                `UFC_OFF_STATUS: begin
                    st_nxt.rdata = {4'h0, tx_below_thr, rx_thr_reached, st_r.rx_req_n, st_r.tx_req_n,
                                    2'h0, st_r.cfg.rx_thr_field, st_r.cfg.tx_thr_field, st_r.cfg.dma_mode,
                                    st_r.cfg.enable, 2'h0, rx_cnt, 2'h0, tx_cnt};
                end
                default: st_nxt.rresp = `UFC_RESP_SLVERR;
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        // dma request outputs, active low
        if (mode1) begin
            if (tx_cnt == `UFC_FIFO_FULL) begin
                st_nxt.tx_req_n = 1'b1;
            end else if (tx_cnt <= tx_thr) begin
                st_nxt.tx_req_n = 1'b0;
            end
            // level or time-out asks, set wins over release
            if (rx_thr_reached || rx_timeout_i) begin
                st_nxt.rx_req_n = 1'b0;
            end else if (rx_cnt == '0) begin
                st_nxt.rx_req_n = 1'b1;
            end
        end else begin
            st_nxt.tx_req_n = (tx_cnt != '0);
            st_nxt.rx_req_n = (rx_cnt == '0);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
            st_r.tx_req_n <= 1'b0;
            st_r.rx_req_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_tx_mode0_empty: assert property (!mode1 && tx_cnt == '0 |=> !tx_dma_request_n_o)
        else $error("tx request not low with empty transmit side");
    a_tx_mode0_load: assert property (!mode1 && $rose(tx_cnt != '0) |-> ##1 tx_dma_request_n_o)
        else $error("tx request not released after load");
    a_rx_mode0_wait: assert property (!mode1 && rx_cnt != '0 |=> !rx_dma_request_n_o)
        else $error("rx request not low with data waiting");
    a_rx_mode0_idle: assert property (!mode1 && rx_cnt == '0 |=> rx_dma_request_n_o)
        else $error("rx request not released when empty");
    a_tx_full_m1: assert property (mode1 && tx_cnt == `UFC_FIFO_FULL |=> tx_dma_request_n_o)
        else $error("tx request not high when full");
    a_tx_level_m1: assert property (mode1 && tx_cnt <= tx_thr |=> !tx_dma_request_n_o)
        else $error("tx request not low at trigger level");
    a_rx_level_m1: assert property (mode1 && (rx_cnt >= rx_thr || rx_timeout_i) |=> !rx_dma_request_n_o)
        else $error("rx request not low at level or time-out");
    a_rx_hold_m1: assert property (mode1 && !rx_dma_request_n_o && rx_cnt != '0 |=> !rx_dma_request_n_o)
        else $error("rx request released before empty");
    a_tx_clear_fifo: assert property (st_r.tx_clr |=> tx_cnt == '0 ##1 !st_r.tx_clr)
        else $error("transmit fifo not emptied by clear");
    a_rx_clear_fifo: assert property (st_r.rx_clr |=> rx_cnt == '0)
        else $error("receive fifo not emptied by clear");
    // disabling keeps bytes already queued, so only a side already down to one byte is held there
    a_off_depth_one: assert property (!st_r.cfg.enable && tx_cnt <= 6'h01 |=> tx_cnt <= 6'h01)
        else $error("fifo deeper than one while disabled");
    a_cfg_ignored: assert property (wr_exec && st_r.aw_addr == `UFC_OFF_FIFO_CONTROL && !st_r.w_data[0]
        |=> $stable(st_r.cfg.dma_mode) && $stable(st_r.cfg.rx_thr_field) && !st_r.tx_clr && !st_r.rx_clr)
        else $error("control fields changed with enable zero");
    a_rx_full_accept: assert property (st_r.cfg.enable && rx_cnt < `UFC_FIFO_FULL |-> rx_ready_o)
        else $error("receive side refused below full");

    c_rx_timeout: cover property (mode1 && rx_timeout_i && rx_cnt != '0 ##1 !rx_dma_request_n_o);
    c_tx_full: cover property (mode1 && tx_cnt == `UFC_FIFO_FULL);
    c_rx_level: cover property (mode1 && rx_cnt == rx_thr);
    c_tx_clear: cover property (st_r.tx_clr && tx_cnt != '0);
endmodule : ufc_top

/* ufc_regs.svh */
// Purpose: register offsets, field positions, reset values and thresholds of the fifo control block
// Assumes: 4-bit byte address on the register bus, 32-bit data
// Notes: definitions only
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH

`define UFC_ADDR_W 4
`define UFC_OFF_FIFO_CONTROL 4'h0
`define UFC_OFF_TX_HOLDING 4'h4
`define UFC_OFF_RX_HOLDING 4'h8
`define UFC_OFF_STATUS 4'hC

`define UFC_FCR_EN_BIT 0
`define UFC_FCR_RXCLR_BIT 1
`define UFC_FCR_TXCLR_BIT 2
`define UFC_FCR_DMA_BIT 3
`define UFC_FCR_TXTHR_LSB 4
`define UFC_FCR_RXTHR_LSB 6
`define UFC_FCR_RESET 8'h00

`define UFC_FIFO_DEPTH 32
`define UFC_FIFO_FULL 6'h20
`define UFC_DATA_W 8
`define UFC_CNT_W 6
`define UFC_LIMIT_DISABLED 6'h01

`define UFC_RX_THR_0 6'h08
`define UFC_RX_THR_1 6'h10
`define UFC_RX_THR_2 6'h18
`define UFC_RX_THR_3 6'h1C
`define UFC_TX_THR_0 6'h10
`define UFC_TX_THR_1 6'h08
`define UFC_TX_THR_2 6'h18
`define UFC_TX_THR_3 6'h1E

`define UFC_RESP_OKAY 2'h0
`define UFC_RESP_SLVERR 2'h2

`endif

/* ufc_pkg.sv */
// Purpose: types shared by the fifo control block
// Assumes: constants come from ufc_regs.svh
// Notes: none
package ufc_pkg;

    typedef struct packed {
        logic [1:0] rx_thr_field;
        logic [1:0] tx_thr_field;
        logic dma_mode;
        logic enable;
    } ufc_cfg_t;

    typedef struct packed {
        ufc_cfg_t cfg;
        logic tx_clr;
        logic rx_clr;
        logic aw_held;
        logic [3:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic tx_req_n;
        logic rx_req_n;
    } ufc_state_t;

endpackage : ufc_pkg

/* ufc_line_model.sv */
// Purpose: line side model, standing in for the transmit shift register and the receiver
// Assumes: the bench calls its tasks right after a rising edge
// Notes: pops only when told, so the transmit fifo can be filled while it stalls
`timescale 1ns/10ps
module ufc_line_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_timeout_o
);
    initial begin
        tx_ready_o = 1'b0;
        rx_data_o = 8'hA5;
        rx_valid_o = 1'b0;
        rx_timeout_o = 1'b0;
    end
    ////////////////////////////////////////
    task automatic push(input logic [7:0] b);
        rx_data_o <= b;
        rx_valid_o <= 1'b1;
        do @(posedge ref_clk_i); while (!rx_ready_i);
        rx_valid_o <= 1'b0;
        // released lines show the inverse so a stale byte never looks valid
        rx_data_o <= ~b;
        @(posedge ref_clk_i);
    endtask : push
    task automatic pop(input int n);
        repeat (n) begin
            tx_ready_o <= 1'b1;
            do @(posedge ref_clk_i); while (!tx_valid_i);
            tx_ready_o <= 1'b0;
            repeat (1 + $urandom_range(0, 2)) @(posedge ref_clk_i);
        end
    endtask : pop
    task automatic time_out();
        rx_timeout_o <= 1'b1;
        @(posedge ref_clk_i);
        rx_timeout_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask : time_out
endmodule : ufc_line_model

/* testbench.sv */
// Purpose: self-checking bench of the fifo control block
// Assumes: line model pops and feeds bytes on command
// Notes: reads and popped bytes are checked by a monitor against queued notes
`timescale 1ns/10ps
`include "ufc_regs.svh"
module testbench;
    import ufc_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, txv, txr, rxv, rxr, rxto, tx_n, rx_n;
    logic [1:0] bresp, rresp;
    logic [7:0] txd, rxd, b;
    ufc_cfg_t cfg;
    logic [33:0] rexp[$], rmask[$];
    logic [7:0] txq[$], rxq[$];
    logic [1:0] bexp[$];
    int mismatches = 0;
    int check_count = 0;
    int tx_thr[4] = '{16, 8, 24, 30};
    int rx_thr[4] = '{8, 16, 24, 28};
    always #50 ref_clk = ~ref_clk;
    ufc_top i_ufc_top (.ref_clk_i(ref_clk), .reset_i(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_data_o(txd), .tx_valid_o(txv),
        .tx_ready_i(txr), .rx_data_i(rxd), .rx_valid_i(rxv), .rx_ready_o(rxr), .rx_timeout_i(rxto),
        .cfg_o(cfg), .tx_dma_request_n_o(tx_n), .rx_dma_request_n_o(rx_n));
    ufc_line_model i_ufc_line_model (.ref_clk_i(ref_clk), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
        .rx_data_o(rxd), .rx_valid_o(rxv), .rx_ready_i(rxr), .rx_timeout_o(rxto));
    ////////////////////////////////////////
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input logic [33:0] m);
        check_count++;
        if ((seen & m) !== (exp & m)) begin
            mismatches++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic lvl(input logic seen, input logic exp);
        chk({33'h0, seen}, {33'h0, exp}, '1);
    endtask : lvl
    // request outputs lag the counts by a cycle, so let them land
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask : settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        bexp.push_back((a == `UFC_OFF_FIFO_CONTROL || a == `UFC_OFF_TX_HOLDING) ? `UFC_RESP_OKAY : `UFC_RESP_SLVERR);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge ref_clk);
            if (awvalid && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge ref_clk); while (!bvalid);
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
        rexp.push_back(e);
        rmask.push_back(m);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge ref_clk); while (!rvalid);
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic rd_rx();
        rd(`UFC_OFF_RX_HOLDING, {26'h0, rxq.pop_front()}, '1);
    endtask : rd_rx
    task automatic put_rx();
        b = 8'($urandom);
        rxq.push_back(b);
        i_ufc_line_model.push(b);
    endtask : put_rx
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rvalid && rready) begin
            chk({rresp, rdata}, rexp.pop_front(), rmask.pop_front());
        end
        if (txv && txr) begin
            chk({26'h0, txd}, {26'h0, txq.pop_front()}, '1);
        end
        if (bvalid && bready) begin
            chk({32'h0, bresp}, {32'h0, bexp.pop_front()}, '1);
        end
    end
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #5000000;
        mismatches++;
        results();
    end
    initial begin
        void'($urandom(44259));
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk({28'h0, cfg}, 34'h0, '1);
        lvl(tx_n, 1'b0);
        lvl(rx_n, 1'b1);
        rd(`UFC_OFF_FIFO_CONTROL, 34'h0, '1);
        rd(4'h2, 34'h2_0000_0000, 34'h3_0000_0000);
        wr(`UFC_OFF_RX_HOLDING, 8'h00);
        $display("test reset done");
        b = 8'($urandom);
        txq.push_back(b);
        wr(`UFC_OFF_TX_HOLDING, b);
        settle();
        lvl(tx_n, 1'b1);
        i_ufc_line_model.pop(1);
        settle();
        lvl(tx_n, 1'b0);
        put_rx();
        settle();
        lvl(rx_n, 1'b0);
        rd_rx();
        settle();
        lvl(rx_n, 1'b1);
        wr(`UFC_OFF_FIFO_CONTROL, 8'hF8);
        settle();
        chk({28'h0, cfg}, 34'h0, '1);
        $display("test mode 0 done");
        for (int f = 0; f < 4; f++) begin
            i_ufc_line_model.push(8'h3C);
            wr(`UFC_OFF_FIFO_CONTROL, 8'(f << 6) | 8'h0B);
            settle();
            chk({28'h0, cfg}, 34'(f << 4) | 34'h3, '1);
            rd(`UFC_OFF_STATUS, 34'h0, 34'h3_0000_3F00);
            for (int k = 0; k < rx_thr[f]; k++) begin
                put_rx();
                if (k == rx_thr[f] - 2) begin
                    settle();
                    lvl(rx_n, 1'b1);
                end
            end
            settle();
            lvl(rx_n, 1'b0);
            rd(`UFC_OFF_STATUS, 34'h0_0400_0000, 34'h3_0400_0000);
            repeat (rx_thr[f]) begin
                lvl(rx_n, 1'b0);
                rd_rx();
                settle();
            end
            lvl(rx_n, 1'b1);
        end
        put_rx();
        settle();
        lvl(rx_n, 1'b1);
        i_ufc_line_model.time_out();
        settle();
        lvl(rx_n, 1'b0);
        rd_rx();
        settle();
        lvl(rx_n, 1'b1);
        $display("test rx mode 1 done");
        for (int f = 0; f < 4; f++) begin
            wr(`UFC_OFF_FIFO_CONTROL, 8'(f << 4) | 8'h0D);
            settle();
            txq.delete();
            rd(`UFC_OFF_STATUS, 34'h0_0800_0000, 34'h3_0800_003F);
            lvl(tx_n, 1'b0);
            for (int k = 1; k <= 32; k++) begin
                b = 8'($urandom);
                txq.push_back(b);
                wr(`UFC_OFF_TX_HOLDING, b);
                if (k >= 31) begin
                    settle();
                    lvl(tx_n, k == 32);
                end
            end
            i_ufc_line_model.pop(31 - tx_thr[f]);
            settle();
            lvl(tx_n, 1'b1);
            i_ufc_line_model.pop(1);
            settle();
            lvl(tx_n, 1'b0);
        end
        $display("test tx mode 1 done");
        wr(`UFC_OFF_FIFO_CONTROL, 8'h07);
        settle();
        txq.delete();
        lvl(tx_n, 1'b0);
        repeat (2) begin
            put_rx();
            b = 8'($urandom);
            txq.push_back(b);
            wr(`UFC_OFF_TX_HOLDING, b);
        end
        settle();
        lvl(rx_n, 1'b0);
        lvl(tx_n, 1'b1);
        rd(`UFC_OFF_STATUS, 34'h0_0001_0202, 34'h3_0003_3F3F);
        rd_rx();
        rd_rx();
        settle();
        lvl(rx_n, 1'b1);
        i_ufc_line_model.pop(2);
        settle();
        lvl(tx_n, 1'b0);
        $display("test fifo mode 0 done");
        results();
    end
endmodule : testbench
